// file: rtl/gated_sixteen_bit_timer.sv
// Summary of operation
// - The counter is a 16-bit up-counter read and written as a high and a low byte.
// - Writing either count byte replaces that byte of the running count at once.
// - Off while the on bit is 0; always counting with gate enable 0; gated otherwise.
// - The instruction clock source makes a timer that advances once per one, two, four or eight instruction cycles.
// - Internal sources advance on multiples of the system clock set by the prescaler.
// - With the full-rate system clock the count rises four per instruction cycle.
// - The external source counts rising pin edges, synchronised or taken directly.
// - In counter mode a falling edge must precede the first counting rising edge.
// - Source code 00 instruction clock, 01 system clock, 10 oscillator/pin, 11 reserved.
// - The gate accepts the gate pin or either comparator output as its source.
`timescale 1ns/1ns
`include "timer_defs.svh"

module gated_sixteen_bit_timer #(
    parameter int COUNT_WIDTH = 16,
    parameter int ADDR_WIDTH  = 3
) (
    // Clock, reset and freeze
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // Register port
    input  wire logic [ADDR_WIDTH-1:0]  addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [7:0]             rdata,
    // Clock and gate inputs
    input  wire logic                   external_clock_pin,
    input  wire logic                   osc_pin,
    input  wire logic                   gate_pin,
    input  wire logic                   comparator_one,
    input  wire logic                   comparator_two,
    // Observed state
    output logic [COUNT_WIDTH-1:0]      count_value,
    output logic                        counting
);

    // Control state
    timer_pkg::clock_source_type clock_source_field;
    timer_pkg::gate_source_type  gate_select_reg;
    logic [1:0]                  prescale_reg;
    logic                        dedicated_osc_enable;
    logic                        async_mode_reg;
    logic                        timer_on_bit;
    logic                        gate_enable_bit;
    logic                        gate_polarity_reg;

    // Counting state
    logic [COUNT_WIDTH-1:0]      count_reg;
    logic [COUNT_WIDTH-1:0]      count_next;
    logic [1:0]                  div_reg;
    logic [2:0]                  ps_cnt_reg;
    logic                        armed_reg;
    logic                        ext_raw_reg;
    logic                        ext_raw_prev_reg;
    logic [7:0]                  rdata_reg;
    logic                        counting_reg;

    // Decoded strobes and conditioned inputs
    logic                        wr_low;
    logic                        wr_high;
    logic                        wr_ctrl;
    logic                        wr_gate;
    logic                        count_write;
    logic                        ext_sync_level;
    logic                        ext_sync_rise;
    logic                        ext_sync_fall;
    logic                        osc_rise;
    logic                        osc_fall;
    logic                        gate_pin_level;
    logic                        comp1_level;
    logic                        comp2_level;
    logic                        gate_src_level;
    logic                        gate_active;
    logic                        run;
    logic                        instr_tick;
    logic                        src_tick;
    logic                        src_rise;
    logic                        src_fall;
    logic                        counter_mode;
    logic                        ps_tick;
    logic [3:0]                  ps_last;

    assign wr_low      = wr && (addr == `ADDR_COUNT_LOW);
    assign wr_high     = wr && (addr == `ADDR_COUNT_HIGH);
    assign wr_ctrl     = wr && (addr == `ADDR_TIMER_CONTROL);
    assign wr_gate     = wr && (addr == `ADDR_GATE_CONTROL);
    assign count_write = wr_low || wr_high;

    // Input conditioning
    edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_ext_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (external_clock_pin),
        .level_q (ext_sync_level),
        .rise    (ext_sync_rise),
        .fall    (ext_sync_fall)
    );

    edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_osc_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (osc_pin),
        .level_q (),
        .rise    (osc_rise),
        .fall    (osc_fall)
    );

    edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_gate_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (gate_pin),
        .level_q (gate_pin_level),
        .rise    (),
        .fall    ()
    );

    edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_comp1_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (comparator_one),
        .level_q (comp1_level),
        .rise    (),
        .fall    ()
    );

    edge_sync #(
        .RESET_LEVEL (1'b0)
    ) u_comp2_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .din     (comparator_two),
        .level_q (comp2_level),
        .rise    (),
        .fall    ()
    );

    // Direct capture of the pin; it skips one stage of latency for async mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_raw_reg      <= 1'b0;
            ext_raw_prev_reg <= 1'b0;
        end else if (ce) begin
            ext_raw_reg      <= external_clock_pin;
            ext_raw_prev_reg <= ext_raw_reg;
        end
    end

    // Control register writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_field   <= timer_pkg::SRC_INSTR;
            prescale_reg         <= `PS_RESET;
            dedicated_osc_enable <= 1'b0;
            async_mode_reg       <= 1'b0;
            timer_on_bit         <= 1'b0;
        end else if (ce && wr_ctrl) begin
            clock_source_field   <= timer_pkg::clock_source_type'(
                                        wdata[`CTRL_SRC_HI:`CTRL_SRC_LO]);
            prescale_reg         <= wdata[`CTRL_PS_HI:`CTRL_PS_LO];
            dedicated_osc_enable <= wdata[`CTRL_OSC_EN];
            async_mode_reg       <= wdata[`CTRL_ASYNC];
            timer_on_bit         <= wdata[`CTRL_ON];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_enable_bit   <= 1'b0;
            gate_polarity_reg <= 1'b0;
            gate_select_reg   <= timer_pkg::GATE_FROM_PIN;
        end else if (ce && wr_gate) begin
            gate_enable_bit   <= wdata[`GATE_EN];
            gate_polarity_reg <= wdata[`GATE_POL];
            gate_select_reg   <= timer_pkg::gate_source_type'(
                                     wdata[`GATE_SEL_HI:`GATE_SEL_LO]);
        end
    end

    always_comb begin
        unique case (gate_select_reg)
            timer_pkg::GATE_FROM_PIN:   gate_src_level = gate_pin_level;
            timer_pkg::GATE_FROM_COMP1: gate_src_level = comp1_level;
            timer_pkg::GATE_FROM_COMP2: gate_src_level = comp2_level;
            timer_pkg::GATE_FROM_PIN_B: gate_src_level = gate_pin_level;
        endcase
    end

    // Polarity 0 means the gate opens while its source is high
    assign gate_active = gate_src_level ^ gate_polarity_reg;

    assign run = timer_on_bit && (!gate_enable_bit || gate_active);

    // Instruction clock divider runs freely so the phase is stable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= `DIV_RESET;
        end else if (ce) begin
            div_reg <= div_reg + `DIV_STEP;
        end
    end

    assign instr_tick = (div_reg == `DIV_LAST);

    // External edges: oscillator when enabled, otherwise the pin
    always_comb begin
        if (dedicated_osc_enable) begin
            src_rise = osc_rise;
            src_fall = osc_fall;
        end else if (async_mode_reg) begin
            src_rise = ext_raw_reg & ~ext_raw_prev_reg;
            src_fall = ~ext_raw_reg & ext_raw_prev_reg;
        end else begin
            src_rise = ext_sync_rise;
            src_fall = ext_sync_fall;
        end
    end

    always_comb begin
        counter_mode = 1'b0;
        unique case (clock_source_field)
            timer_pkg::SRC_INSTR:    src_tick = instr_tick;
            timer_pkg::SRC_SYSTEM:   src_tick = 1'b1;
            timer_pkg::SRC_EXTERNAL: begin
                src_tick     = src_rise && armed_reg;
                counter_mode = 1'b1;
            end
            timer_pkg::SRC_RESERVED: src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (ce) begin
            if (!timer_on_bit || !counter_mode) begin
                armed_reg <= 1'b0;
            end else if (src_fall) begin
                armed_reg <= 1'b1;
            end else if (count_write) begin
                armed_reg <= 1'b0;
            end
        end
    end

    // prescaler ratio of one, two, four or eight
    assign ps_last = (`PS_ONE << prescale_reg) - `PS_ONE;
    assign ps_tick = run && src_tick && ({1'b0, ps_cnt_reg} >= ps_last);

    // Prescaler restarts on a count write so the next tick is a full period
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ps_cnt_reg <= `PS_CNT_RESET;
        end else if (ce) begin
            if (count_write || !timer_on_bit) begin
                ps_cnt_reg <= `PS_CNT_RESET;
            end else if (run && src_tick) begin
                if (ps_tick) begin
                    ps_cnt_reg <= `PS_CNT_RESET;
                end else begin
                    ps_cnt_reg <= ps_cnt_reg + `PS_CNT_STEP;
                end
            end
        end
    end

    always_comb begin
        count_next = count_reg;
        if (wr_low) begin
            count_next[7:0] = wdata;
        end else if (wr_high) begin
            count_next[15:8] = wdata;
        end else if (ps_tick) begin
            count_next = count_reg + `COUNT_STEP;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `COUNT_RESET;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            counting_reg <= 1'b0;
        end else if (ce) begin
            counting_reg <= run;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= `BYTE_ZERO;
        end else if (ce) begin
            rdata_reg <= `BYTE_ZERO;
            if (rd) begin
                unique case (addr)
                    `ADDR_COUNT_LOW:     rdata_reg <= count_reg[7:0];
                    `ADDR_COUNT_HIGH:    rdata_reg <= count_reg[15:8];
                    `ADDR_TIMER_CONTROL: begin
                        rdata_reg[`CTRL_SRC_HI:`CTRL_SRC_LO] <= clock_source_field;
                        rdata_reg[`CTRL_PS_HI:`CTRL_PS_LO]   <= prescale_reg;
                        rdata_reg[`CTRL_OSC_EN]              <= dedicated_osc_enable;
                        rdata_reg[`CTRL_ASYNC]               <= async_mode_reg;
                        rdata_reg[`CTRL_ON]                  <= timer_on_bit;
                    end
                    `ADDR_GATE_CONTROL: begin
                        rdata_reg[`GATE_EN]                   <= gate_enable_bit;
                        rdata_reg[`GATE_POL]                  <= gate_polarity_reg;
                        rdata_reg[`GATE_SEL_HI:`GATE_SEL_LO]  <= gate_select_reg;
                    end
                    `ADDR_STATUS: begin
                        rdata_reg[`STAT_GATE]  <= gate_active;
                        rdata_reg[`STAT_RUN]   <= run;
                        rdata_reg[`STAT_ARMED] <= armed_reg;
                    end
                    default:             rdata_reg <= `BYTE_ZERO;
                endcase
            end
        end
    end

    assign rdata       = rdata_reg;
    assign count_value = count_reg;
    assign counting    = counting_reg;

endmodule

// file: rtl/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Register addresses on the plain register port
`define ADDR_COUNT_LOW      3'h0
`define ADDR_COUNT_HIGH     3'h1
`define ADDR_TIMER_CONTROL  3'h2
`define ADDR_GATE_CONTROL   3'h3
`define ADDR_STATUS         3'h4

// Timer control register fields
`define CTRL_SRC_HI         7
`define CTRL_SRC_LO         6
`define CTRL_PS_HI          5
`define CTRL_PS_LO          4
`define CTRL_OSC_EN         3
`define CTRL_ASYNC          2
`define CTRL_ON             0

// Gate control register fields
`define GATE_EN             7
`define GATE_POL            6
`define GATE_SEL_HI         1
`define GATE_SEL_LO         0

// Status register fields
`define STAT_GATE           0
`define STAT_RUN            1
`define STAT_ARMED          2

// Reset values and constants
`define COUNT_RESET         16'h0000
`define COUNT_STEP          16'h0001
`define SRC_RESET           2'h0
`define PS_RESET            2'h0
`define PS_CNT_RESET        3'h0
`define PS_CNT_STEP         3'h1
`define PS_ONE              4'h1
`define DIV_RESET           2'h0
`define DIV_STEP            2'h1
`define DIV_LAST            2'h3
`define GSEL_RESET          2'h0
`define BYTE_ZERO           8'h00

`endif

// file: rtl/timer_pkg.sv
package timer_pkg;

    typedef enum logic [1:0] {
        SRC_INSTR    = 2'b00,
        SRC_SYSTEM   = 2'b01,
        SRC_EXTERNAL = 2'b10,
        SRC_RESERVED = 2'b11
    } clock_source_type;

    typedef enum logic [1:0] {
        GATE_FROM_PIN   = 2'b00,
        GATE_FROM_COMP1 = 2'b01,
        GATE_FROM_COMP2 = 2'b10,
        GATE_FROM_PIN_B = 2'b11
    } gate_source_type;

endpackage

// file: rtl/edge_sync.sv
`timescale 1ns/1ns

module edge_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    // Raw input and conditioned outputs
    input  wire logic din,
    output logic      level_q,
    output logic      rise,
    output logic      fall
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    // First stage feeds only the second one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
        end else if (ce) begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    assign level_q = stage2_reg;
    assign rise    = stage2_reg & ~stage3_reg;
    assign fall    = ~stage2_reg & stage3_reg;

endmodule

// file: testbench/gated_timer_props.sv
`timescale 1ns/1ns
`include "timer_defs.svh"

module gated_timer_props #(
    parameter int COUNT_WIDTH = 16,
    parameter int ADDR_WIDTH  = 3
) (
    // Clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   ce,
    // Register port
    input wire logic [ADDR_WIDTH-1:0]  addr,
    input wire logic [7:0]             wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [7:0]             rdata,
    // Observed count
    input wire logic [COUNT_WIDTH-1:0] count_value
);
    logic [7:0] ctrl_m_reg;
    logic [7:0] gate_m_reg;
    logic       wr_ok;

    assign wr_ok = wr && ce;

    // Shadows of the control registers, updated on the same edge as the real ones
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_m_reg <= 8'h00;
        end else if (wr_ok && addr == `ADDR_TIMER_CONTROL) begin
            ctrl_m_reg <= wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_m_reg <= 8'h00;
        end else if (wr_ok && addr == `ADDR_GATE_CONTROL) begin
            gate_m_reg <= wdata;
        end
    end

    default clocking dclk @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property ($past(ce) && !$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_read_low: assert property ($past(rd && ce && addr == `ADDR_COUNT_LOW)
        && $stable(count_value) |-> rdata == count_value[7:0])
        else $error("low byte read mismatch");
    a_write_low: assert property (wr_ok && addr == `ADDR_COUNT_LOW
        |=> count_value[7:0] == $past(wdata))
        else $error("low byte write not applied");
    a_write_high: assert property (wr_ok && addr == `ADDR_COUNT_HIGH
        |=> count_value[15:8] == $past(wdata))
        else $error("high byte write not applied");
    a_off_holds: assert property (!ctrl_m_reg[0] && !wr_ok |=> $stable(count_value))
        else $error("count moved while off");
    a_reserved_hold: assert property (ctrl_m_reg[7:6] == 2'b11 && !wr_ok
        |=> $stable(count_value))
        else $error("count moved on reserved source");
    a_system_step: assert property (ctrl_m_reg[7:4] == 4'h4 && ctrl_m_reg[0]
        && !gate_m_reg[7] && ce && !wr |=> count_value == $past(count_value) + 16'h0001)
        else $error("system clock source not one per clock");
    a_instr_rate: assert property ((ctrl_m_reg == 8'h01 && !gate_m_reg[7]
        && ce && !wr) [*4] |=> count_value == $past(count_value, 4) + 16'h0001)
        else $error("instruction clock source not one per four clocks");
endmodule

bind gated_sixteen_bit_timer gated_timer_props #(
    .COUNT_WIDTH(COUNT_WIDTH),
    .ADDR_WIDTH(ADDR_WIDTH)
) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .count_value(count_value)
);

// file: testbench/ext_clock_source.sv
`timescale 1ns/1ns

module ext_clock_source (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Burst request
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    // Pin side
    output logic            pin,
    output logic            busy
);
    logic [8:0] edges_reg;
    logic [2:0] tick_reg;

    // Pin rests low between bursts so no stray edge reaches the counter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b0;
            busy <= 1'b0;
            edges_reg <= 9'h000;
            tick_reg <= 3'h0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            edges_reg <= {pulses, 1'b0};
            tick_reg <= 3'h4;
        end else if (busy) begin
            if (tick_reg != 3'h0) begin
                tick_reg <= tick_reg - 3'h1;
            end else if (edges_reg == 9'h000) begin
                busy <= 1'b0;
            end else begin
                pin <= ~pin;
                edges_reg <= edges_reg - 9'h001;
                tick_reg <= 3'h4;
            end
        end
    end
endmodule

// file: testbench/tb_gated_sixteen_bit_timer.sv
`timescale 1ns/1ns
`include "timer_defs.svh"

module tb_gated_sixteen_bit_timer;
    logic        clk_sys;
    logic        rst_n;
    logic        ce;
    logic [2:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        gate_pin;
    logic        comparator_one;
    logic        comparator_two;
    logic        osc_sel;
    logic        start;
    logic [7:0]  pulses;
    logic        pin_w;
    logic        busy;
    logic        ext_w;
    logic        osc_w;
    logic [15:0] count_value;
    logic        counting;
    logic [7:0]  d;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  c;
    logic [7:0]  n;
    int          seed;
    int          n_fail;
    int          compares;
    int          cycles;

    // The unselected source pin idles low
    assign ext_w = osc_sel ? 1'b0 : pin_w;
    assign osc_w = osc_sel ? pin_w : 1'b0;

    gated_sixteen_bit_timer dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .external_clock_pin(ext_w), .osc_pin(osc_w),
        .gate_pin(gate_pin), .comparator_one(comparator_one),
        .comparator_two(comparator_two), .count_value(count_value), .counting(counting)
    );

    ext_clock_source partner (
        .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .pulses(pulses),
        .pin(pin_w), .busy(busy)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] ticks(input int window, input int div);
        return 16'(window / div);
    endfunction

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Passing through off clears the prescaler and the arming state
    task automatic cfg(input logic [7:0] v);
        wr_reg(`ADDR_TIMER_CONTROL, 8'h00);
        wr_reg(`ADDR_TIMER_CONTROL, v);
    endtask

    task automatic measure(input int win, input logic [15:0] exp);
        logic [15:0] c0;
        repeat (4) @(posedge clk_sys);
        #1;
        c0 = count_value;
        repeat (win) @(posedge clk_sys);
        #1;
        check(count_value - c0, exp);
        // Hand back on a clock edge so callers drive inputs there
        @(posedge clk_sys);
    endtask

    task automatic burst(input logic [7:0] k);
        @(posedge clk_sys);
        pulses <= k;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 400 && busy; i++) @(posedge clk_sys);
        repeat (6) @(posedge clk_sys);
    endtask

    // Unselected gate inputs get random levels to expose a wrong selection
    task automatic set_gate(input int g, input logic v);
        logic [2:0] r;
        r = 3'($random(seed));
        gate_pin <= (g == 0 || g == 3) ? v : r[0];
        comparator_one <= (g == 1) ? v : r[1];
        comparator_two <= (g == 2) ? v : r[2];
    endtask

    initial begin
        seed = 42;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        gate_pin = 1'b0;
        comparator_one = 1'b0;
        comparator_two = 1'b0;
        osc_sel = 1'b0;
        start = 1'b0;
        pulses = 8'h00;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        check(count_value, `COUNT_RESET);
        rd_reg(`ADDR_TIMER_CONTROL, d);
        check({8'h00, d}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            wr_reg(`ADDR_COUNT_LOW, lo);
            wr_reg(`ADDR_COUNT_HIGH, hi);
            rd_reg(`ADDR_COUNT_LOW, d);
            check({8'h00, d}, {8'h00, lo});
            rd_reg(`ADDR_COUNT_HIGH, d);
            check({8'h00, d}, {8'h00, hi});
            check(count_value, {hi, lo});
        end
        wr_reg(3'h5, 8'hFF);
        rd_reg(3'h5, d);
        check({8'h00, d}, 16'h0000);
        cfg(8'h41);
        measure(32, ticks(32, 1));
        ce <= 1'b0;
        measure(20, 16'h0000);
        ce <= 1'b1;
        cfg(8'h01);
        measure(40, ticks(40, 4));
        for (int p = 0; p < 4; p++) begin
            cfg(8'h41 | 8'(p << 4));
            measure(64, ticks(64, 1 << p));
        end
        cfg(8'hC1);
        measure(32, 16'h0000);
        cfg(8'h41);
        for (int g = 0; g < 4; g++) begin
            wr_reg(`ADDR_GATE_CONTROL, 8'h80 | 8'(g));
            set_gate(g, 1'b0);
            measure(16, 16'h0000);
            check({15'h0000, counting}, 16'h0000);
            set_gate(g, 1'b1);
            measure(16, ticks(16, 1));
            check({15'h0000, counting}, 16'h0001);
            rd_reg(`ADDR_STATUS, d);
            check({8'h00, d}, 16'h0003);
        end
        set_gate(0, 1'b0);
        wr_reg(`ADDR_GATE_CONTROL, 8'hC0);
        measure(16, ticks(16, 1));
        wr_reg(`ADDR_GATE_CONTROL, 8'h00);
        measure(16, ticks(16, 1));
        cfg(8'h40);
        measure(16, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            c = (k == 0) ? 8'h81 : (k == 1) ? 8'h85 : 8'h89;
            osc_sel <= c[3];
            wr_reg(`ADDR_COUNT_LOW, 8'h00);
            wr_reg(`ADDR_COUNT_HIGH, 8'h00);
            cfg(c);
            n = 8'(2 + ($random(seed) & 7));
            burst(n);
            check(count_value, {8'h00, n - 8'h01});
            wr_reg(`ADDR_COUNT_LOW, 8'h10);
            burst(8'h03);
            check(count_value, 16'h0012);
        end
        finish_test();
    end
endmodule
